/* src/gcv_pkg.sv */
// Purpose: Shared constants for the general converter control block
// Assumes: AHB-Lite register access, 32-bit data, one word per register
// Notes:   Byte offsets decoded from haddr[7:0]
package gcv_pkg;
  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [7:0] MAIN_CONTROL_OFS = 8'h00;
  localparam logic [7:0] SECOND_CONTROL_OFS = 8'h04;
  localparam logic [7:0] CHANNEL_SELECT_OFS = 8'h08;
  localparam logic [7:0] POS_TRIM_OFS = 8'h0c;
  localparam logic [7:0] NEG_TRIM_OFS = 8'h10;
  localparam logic [7:0] INTERRUPT_CLEAR_OFS = 8'h14;
  localparam logic [7:0] RESULT_OFS = 8'h18;
  localparam logic [7:0] STATUS_OFS = 8'h1c;
  // ----------------------------------------
  // Main control fields
  // ----------------------------------------
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_START_BIT = 1;
  localparam int CTRL_CONT_BIT = 2;
  localparam int CTRL_SE_BIT = 3;
  localparam int CTRL_MUTE_BIT = 4;
  localparam int CTRL_SIGN_BIT = 5;
  localparam int CTRL_CHOP_BIT = 6;
  localparam int CTRL_W = 7;
  // ----------------------------------------
  // Second control fields
  // ----------------------------------------
  localparam int CTRL2_EXP_LSB = 0;
  localparam int EXP_W = 3;
  localparam int CTRL2_ATTN_LSB = 4;
  localparam int ATTN_W = 2;
  localparam int CTRL2_SMPL_LSB = 8;
  localparam int SMPL_W = 4;
  localparam int CTRL2_LOAD_BIT = 12;
  // ----------------------------------------
  // Data widths and reset values
  // ----------------------------------------
  localparam int SAMPLE_W = 10;
  localparam int RESULT_W = 16;
  localparam int TRIM_W = 10;
  localparam logic [TRIM_W-1:0] TRIM_RESET = 10'h200;
  localparam logic [SMPL_W-1:0] SMPL_RESET = 4'h1;
  localparam logic [1:0] CHOP_MIN_SAMPLES = 2'h2;
endpackage

/* src/gcv_avg_if.sv */
// Purpose: Carries the averaging request and sample path between modules
// Assumes: Single clock domain
// Notes:   Top drives start, exponent, chop and sample answers, averager drives the rest
`timescale 1ns/1ns
interface gcv_avg_if;
  logic start;
  logic [gcv_pkg::EXP_W-1:0] exponent;
  logic chop;
  logic busy;
  logic done;
  logic [gcv_pkg::RESULT_W-1:0] result;
  logic smp_req;
  logic smp_odd;
  logic smp_valid;
  logic [gcv_pkg::SAMPLE_W-1:0] smp_data;
  modport ctl (output start, output exponent, output chop, output smp_valid, output smp_data,
               input busy, input done, input result, input smp_req, input smp_odd);
  modport avg (input start, input exponent, input chop, input smp_valid, input smp_data,
               output busy, output done, output result, output smp_req, output smp_odd);
endinterface

/* src/gcv_avg.sv */
// Purpose: Collects 2^n samples and forms a 16-bit left-aligned average
// Assumes: One sample request outstanding at a time
// Notes:   Chop forces at least two samples; smp_odd flips the sign
`timescale 1ns/1ns
module gcv_avg (
  input wire logic clk,
  input wire logic rst,
  gcv_avg_if.avg bus
);
  localparam int ACC_W = gcv_pkg::SAMPLE_W + 7;
  localparam int SH_W = ACC_W + 6;

  typedef enum logic [1:0] {
    GCV_IDLE = 2'b00,
    GCV_REQ = 2'b01,
    GCV_WAIT = 2'b10
  } gcv_avg_e;

  gcv_avg_e state_q;
  logic [7:0] target_q;
  logic [7:0] idx_q;
  logic [ACC_W-1:0] acc_q;
  logic [ACC_W-1:0] acc_d;
  logic [SH_W-1:0] scaled;
  logic last;
  logic [7:0] target_d;
  logic [gcv_pkg::EXP_W-1:0] shift_d;
  logic [gcv_pkg::EXP_W-1:0] shift_q;
  logic req_q;
  logic done_q;
  logic [gcv_pkg::RESULT_W-1:0] result_q;

  assign acc_d = acc_q + ACC_W'(bus.smp_data);
  assign last = (idx_q + 8'h01) == target_q;
  assign scaled = (SH_W'(acc_d) << 6) >> shift_q;

  // Divide by the samples actually taken, so a forced chop pair cannot overflow
  always_comb begin
    target_d = 8'h01 << bus.exponent;
    shift_d = bus.exponent;
    if (bus.chop && bus.exponent == '0) begin
      target_d = 8'(gcv_pkg::CHOP_MIN_SAMPLES);
      shift_d = gcv_pkg::EXP_W'(1);
    end
  end

  // ----------------------------------------
  // Sequencing
  // ----------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= GCV_IDLE;
    end else begin
      case (state_q)
        GCV_IDLE: if (bus.start) state_q <= GCV_REQ;
        GCV_REQ: state_q <= GCV_WAIT;
        GCV_WAIT: if (bus.smp_valid) state_q <= last ? GCV_IDLE : GCV_REQ;
        default: state_q <= GCV_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      target_q <= 8'h01;
      shift_q <= '0;
      idx_q <= 8'h00;
      acc_q <= '0;
    end else if (state_q == GCV_IDLE && bus.start) begin
      target_q <= target_d;
      shift_q <= shift_d;
      idx_q <= 8'h00;
      acc_q <= '0;
    end else if (state_q == GCV_WAIT && bus.smp_valid) begin
      idx_q <= idx_q + 8'h01;
      acc_q <= acc_d;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      req_q <= 1'b0;
      done_q <= 1'b0;
      result_q <= '0;
    end else begin
      req_q <= state_q == GCV_IDLE ? bus.start : (state_q == GCV_WAIT && bus.smp_valid && !last);
      done_q <= state_q == GCV_WAIT && bus.smp_valid && last;
      if (state_q == GCV_WAIT && bus.smp_valid && last) begin
        result_q <= scaled[gcv_pkg::RESULT_W-1:0];
      end
    end
  end

  assign bus.busy = state_q != GCV_IDLE;
  assign bus.done = done_q;
  assign bus.result = result_q;
  assign bus.smp_req = req_q;
  assign bus.smp_odd = idx_q[0];

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_req_single_pulse: assert property (@(posedge clk) disable iff (rst)
    req_q |=> !req_q) else $error("sample request longer than one cycle");
  a_done_after_count: assert property (@(posedge clk) disable iff (rst)
    done_q |-> $past(idx_q) + 8'h01 == target_q) else $error("done before full sample count");
endmodule // gcv_avg

/* src/gcv_ctrl.sv */
// Purpose: Register file and sequencing for the general converter
// Assumes: AHB-Lite single word transfers, zero wait states
// Notes:   Analogue front end answers each sample request with a valid pulse
//
// How it works
// - single_ended_select: 1 single-ended, 0 differential
// - Equal trims set the common-mode level
// - Load bit keeps constant regulator load on
// - Nonzero exponent averages several conversions
// - Start launches when enable is set; interrupt on completion, and start cleared then unless continuous is set
// - Any write to clear register drops interrupt
// - Result register holds completed conversion
// - Two to the exponent samples per result; two when chop is set with a zero exponent
// - Result stored 16-bit left aligned
// - Mute ties input to half reference
// - Sign invert flips offset; chop alternates it
`timescale 1ns/1ns
module gcv_ctrl #(
  parameter int CH_W = 2
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic afe_enable,
  output logic [CH_W-1:0] afe_channel,
  output logic afe_single_ended,
  output logic afe_mute,
  output logic afe_sign,
  output logic [gcv_pkg::ATTN_W-1:0] afe_attenuation,
  output logic [gcv_pkg::SMPL_W-1:0] afe_sampling_time,
  output logic afe_regulator_load,
  output logic [gcv_pkg::TRIM_W-1:0] afe_positive_trim,
  output logic [gcv_pkg::TRIM_W-1:0] afe_negative_trim,
  output logic afe_sample_req,
  input wire logic afe_sample_valid,
  input wire logic [gcv_pkg::SAMPLE_W-1:0] afe_sample_data,
  output logic converter_irq
);
  gcv_avg_if avg_bus ();

  logic [gcv_pkg::CTRL_W-1:0] ctrl_q;
  logic [gcv_pkg::EXP_W-1:0] exp_q;
  logic [gcv_pkg::ATTN_W-1:0] attn_q;
  logic [gcv_pkg::SMPL_W-1:0] smpl_q;
  logic load_q;
  logic [CH_W-1:0] chan_q;
  logic [gcv_pkg::TRIM_W-1:0] pos_trim_q;
  logic [gcv_pkg::TRIM_W-1:0] neg_trim_q;
  logic [gcv_pkg::RESULT_W-1:0] result_q;
  logic irq_q;
  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  logic [31:0] rd_d;
  logic [31:0] rdata_q;
  logic addr_ok;
  logic launch;
  logic wr_ctrl;
  logic done;

  // ----------------------------------------
  // Bus slave
  // ----------------------------------------
  // Zero-wait slave: read data is captured during the address phase
  assign addr_ok = hsel && htrans[1] && hready;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end else begin
      wr_pend_q <= addr_ok && hwrite;
      if (addr_ok) begin
        wr_addr_q <= haddr[7:0];
      end
    end
  end

  always_comb begin
    rd_d = 32'h0000_0000;
    case (haddr[7:0])
      gcv_pkg::MAIN_CONTROL_OFS: rd_d = 32'(ctrl_q);
      gcv_pkg::SECOND_CONTROL_OFS: begin
        rd_d[gcv_pkg::CTRL2_EXP_LSB +: gcv_pkg::EXP_W] = exp_q;
        rd_d[gcv_pkg::CTRL2_ATTN_LSB +: gcv_pkg::ATTN_W] = attn_q;
        rd_d[gcv_pkg::CTRL2_SMPL_LSB +: gcv_pkg::SMPL_W] = smpl_q;
        rd_d[gcv_pkg::CTRL2_LOAD_BIT] = load_q;
      end
      gcv_pkg::CHANNEL_SELECT_OFS: rd_d = 32'(chan_q);
      gcv_pkg::POS_TRIM_OFS: rd_d = 32'(pos_trim_q);
      gcv_pkg::NEG_TRIM_OFS: rd_d = 32'(neg_trim_q);
      gcv_pkg::RESULT_OFS: rd_d = 32'(result_q);
      gcv_pkg::STATUS_OFS: rd_d = {30'h0, avg_bus.busy, irq_q};
      default: rd_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_q <= 32'h0000_0000;
    end else if (addr_ok && !hwrite) begin
      rdata_q <= rd_d;
    end
  end

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  assign wr_ctrl = wr_pend_q && wr_addr_q == gcv_pkg::MAIN_CONTROL_OFS;
  assign done = avg_bus.done;

  // Start is the only bit hardware touches; a software set beats completion
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_q <= '0;
    end else if (wr_ctrl) begin
      ctrl_q <= hwdata[gcv_pkg::CTRL_W-1:0];
    end else if (done && !ctrl_q[gcv_pkg::CTRL_CONT_BIT]) begin
      ctrl_q[gcv_pkg::CTRL_START_BIT] <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      exp_q <= '0;
      attn_q <= '0;
      smpl_q <= gcv_pkg::SMPL_RESET;
      load_q <= 1'b0;
      chan_q <= '0;
    end else if (wr_pend_q && wr_addr_q == gcv_pkg::SECOND_CONTROL_OFS) begin
      exp_q <= hwdata[gcv_pkg::CTRL2_EXP_LSB +: gcv_pkg::EXP_W];
      attn_q <= hwdata[gcv_pkg::CTRL2_ATTN_LSB +: gcv_pkg::ATTN_W];
      smpl_q <= hwdata[gcv_pkg::CTRL2_SMPL_LSB +: gcv_pkg::SMPL_W];
      load_q <= hwdata[gcv_pkg::CTRL2_LOAD_BIT];
    end else if (wr_pend_q && wr_addr_q == gcv_pkg::CHANNEL_SELECT_OFS) begin
      chan_q <= hwdata[CH_W-1:0];
    end
  end

  // Trims reset to mid-scale so an untrimmed converter is centred
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pos_trim_q <= gcv_pkg::TRIM_RESET;
      neg_trim_q <= gcv_pkg::TRIM_RESET;
    end else if (wr_pend_q && wr_addr_q == gcv_pkg::POS_TRIM_OFS) begin
      pos_trim_q <= hwdata[gcv_pkg::TRIM_W-1:0];
    end else if (wr_pend_q && wr_addr_q == gcv_pkg::NEG_TRIM_OFS) begin
      neg_trim_q <= hwdata[gcv_pkg::TRIM_W-1:0];
    end
  end

  // ----------------------------------------
  // Conversion sequencing
  // ----------------------------------------
  assign launch = ctrl_q[gcv_pkg::CTRL_START_BIT] && ctrl_q[gcv_pkg::CTRL_ENABLE_BIT]
                  && !avg_bus.busy && !done;
  assign avg_bus.start = launch;
  assign avg_bus.exponent = exp_q;
  assign avg_bus.chop = ctrl_q[gcv_pkg::CTRL_CHOP_BIT];
  assign avg_bus.smp_valid = afe_sample_valid;
  assign avg_bus.smp_data = afe_sample_data;

  gcv_avg u_avg (
    .clk(clk),
    .rst(rst),
    .bus(avg_bus)
  );

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      result_q <= '0;
    end else if (done) begin
      result_q <= avg_bus.result;
    end
  end

  // Completion sets win over a clear in the same cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_q <= 1'b0;
    end else if (done) begin
      irq_q <= 1'b1;
    end else if (wr_pend_q && wr_addr_q == gcv_pkg::INTERRUPT_CLEAR_OFS) begin
      irq_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // Front-end drive
  // ----------------------------------------
  assign converter_irq = irq_q;
  assign afe_enable = ctrl_q[gcv_pkg::CTRL_ENABLE_BIT];
  assign afe_channel = chan_q;
  assign afe_single_ended = ctrl_q[gcv_pkg::CTRL_SE_BIT];
  assign afe_mute = ctrl_q[gcv_pkg::CTRL_MUTE_BIT];
  assign afe_sign = ctrl_q[gcv_pkg::CTRL_SIGN_BIT]
                    ^ (ctrl_q[gcv_pkg::CTRL_CHOP_BIT] & avg_bus.smp_odd);
  assign afe_attenuation = attn_q;
  assign afe_sampling_time = smpl_q;
  assign afe_regulator_load = load_q;
  assign afe_positive_trim = pos_trim_q;
  assign afe_negative_trim = neg_trim_q;
  assign afe_sample_req = avg_bus.smp_req;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_irq_on_done: assert property (@(posedge clk) disable iff (rst)
    done |=> irq_q) else $error("interrupt missing after completion");
  a_irq_clear_write: assert property (@(posedge clk) disable iff (rst)
    wr_pend_q && wr_addr_q == gcv_pkg::INTERRUPT_CLEAR_OFS && !done |=> !irq_q)
    else $error("interrupt not cleared by write");
  a_start_self_clear: assert property (@(posedge clk) disable iff (rst)
    done && !wr_ctrl && !ctrl_q[gcv_pkg::CTRL_CONT_BIT] |=> !ctrl_q[gcv_pkg::CTRL_START_BIT])
    else $error("start bit stayed set after completion");
  a_launch_busy: assert property (@(posedge clk) disable iff (rst)
    launch |=> avg_bus.busy && afe_sample_req) else $error("launch did not request a sample");
  a_result_loaded: assert property (@(posedge clk) disable iff (rst)
    done |=> result_q == $past(avg_bus.result)) else $error("result not stored on completion");
  a_trim_masked: assert property (@(posedge clk) disable iff (rst)
    wr_pend_q && wr_addr_q == gcv_pkg::POS_TRIM_OFS
    |=> afe_positive_trim == $past(hwdata[gcv_pkg::TRIM_W-1:0])) else $error("trim write lost");
  a_load_follows: assert property (@(posedge clk) disable iff (rst)
    wr_pend_q && wr_addr_q == gcv_pkg::SECOND_CONTROL_OFS
    |=> afe_regulator_load == $past(hwdata[gcv_pkg::CTRL2_LOAD_BIT]))
    else $error("regulator load bit not applied");
  a_chop_sign: assert property (@(posedge clk) disable iff (rst)
    afe_sample_req && ctrl_q[gcv_pkg::CTRL_CHOP_BIT] && avg_bus.smp_odd
    |-> afe_sign != ctrl_q[gcv_pkg::CTRL_SIGN_BIT]) else $error("chop sign not flipped");
endmodule // gcv_ctrl

/* testbench/gcv_afe_model.sv */
// Purpose: Analogue front end stand-in that answers sample requests
// Assumes: Built-in offset per polarity, trims correct it in the network
// Notes:   Data line toggles when not valid so stale values never match
`timescale 1ns/1ns
module gcv_afe_model #(
  parameter int OFS_P = 24,
  parameter int OFS_N = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic sample_req,
  input wire logic mute,
  input wire logic sign,
  input wire logic single_ended,
  input wire logic [9:0] trim_p,
  input wire logic [9:0] trim_n,
  input wire logic [9:0] level,
  input wire logic [3:0] delay,
  input wire logic [3:0] pin_function,
  output logic valid,
  output logic [9:0] data,
  output int reqs,
  output logic [7:0] sign_hist
);
  logic pend;
  logic [3:0] cnt;
  int t;
  int e;
  // Single-ended trims act at half weight
  always_comb begin
    t = sign ? int'(trim_n) : int'(trim_p);
    e = (sign ? -OFS_N : OFS_P) + (single_ended ? (t - 512) / 2 : t - 512);
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pend <= 1'b0;
      cnt <= 4'h0;
      valid <= 1'b0;
      data <= 10'h0;
      reqs <= 0;
      sign_hist <= 8'h00;
    end else begin
      valid <= 1'b0;
      data <= ~data;
      if (pend && cnt == 4'h0) begin
        valid <= 1'b1;
        // Pin not set to analogue input: the level never reaches the converter
        data <= 10'((mute ? 512 : (pin_function == 4'hf ? int'(level) : 0)) + e);
        pend <= 1'b0;
        sign_hist <= {sign_hist[6:0], sign};
      end else if (pend) begin
        cnt <= cnt - 4'h1;
      end
      if (sample_req) begin
        pend <= 1'b1;
        cnt <= delay;
        reqs <= reqs + 1;
      end
    end
  end
endmodule // gcv_afe_model

/* testbench/gcv_ctrl_test.sv */
// Purpose: Self-checking bench for the converter control block
// Assumes: Zero-wait AHB-Lite slave, front end model on the sample link
// Notes:   One task per scenario, expectations from the model input level and offsets
`timescale 1ns/1ns
`define CHK(got, exp, msg) begin checks_done++; if ((got) !== (exp)) begin bad_count++; \
  $display("mismatch at %0t: %s", $time, msg); end end
module gcv_ctrl_test;
  localparam int OP = 24;
  localparam int ON = 16;
  logic clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, hready, hresp, irq;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
  logic [1:0] htrans = 2'h0, chan;
  logic [2:0] hsize = 3'h2;
  logic en, se, mute, sign, load, req, valid;
  logic [1:0] attn;
  logic [3:0] smpl, delay = 4'h0;
  logic [9:0] tp, tn, data, level = 10'h12c;
  logic [7:0] hist;
  logic [3:0] pin_func = 4'h0;
  int reqs, bad_count = 0, checks_done = 0, cyc = 0;
  gcv_ctrl gcv_ctrl_inst (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hready),
    .hresp(hresp), .hrdata(hrdata), .afe_enable(en), .afe_channel(chan),
    .afe_single_ended(se), .afe_mute(mute), .afe_sign(sign), .afe_attenuation(attn),
    .afe_sampling_time(smpl), .afe_regulator_load(load), .afe_positive_trim(tp),
    .afe_negative_trim(tn), .afe_sample_req(req), .afe_sample_valid(valid),
    .afe_sample_data(data), .converter_irq(irq));
  gcv_afe_model #(.OFS_P(OP), .OFS_N(ON)) gcv_afe_model_inst (.clk(clk), .rst(rst),
    .sample_req(req), .mute(mute), .sign(sign), .single_ended(se), .trim_p(tp), .trim_n(tn),
    .level(level), .delay(delay), .pin_function(pin_func), .valid(valid), .data(data),
    .reqs(reqs), .sign_hist(hist));
  initial begin
    forever #20 clk = ~clk;
  end
  // ----------------------------------------
  // Bus cycles
  // ----------------------------------------
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    xfer(1'b0, a, 32'h0, q);
  endtask
  // Start, wait for completion, fetch result, drop the interrupt
  task automatic convert(input logic [31:0] ctrl, output logic [15:0] res);
    int n;
    n = 0;
    wr(gcv_pkg::MAIN_CONTROL_OFS, ctrl | 32'h2);
    while (irq !== 1'b1 && n < 400) begin
      @(posedge clk);
      n++;
    end
    `CHK(irq, 1'b1, "no completion interrupt")
    rd(gcv_pkg::STATUS_OFS, r);
    `CHK(r, 32'h1, "status after completion")
    rd(gcv_pkg::RESULT_OFS, r);
    res = r[15:0];
    rd(gcv_pkg::MAIN_CONTROL_OFS, r);
    `CHK(r[1], 1'b0, "start bit not cleared")
    wr(gcv_pkg::INTERRUPT_CLEAR_OFS, 32'ha5c3_0f96);
    @(posedge clk);
    `CHK(irq, 1'b0, "interrupt not cleared")
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    rd(gcv_pkg::MAIN_CONTROL_OFS, r);
    `CHK(r, 32'h0, "control reset value")
    rd(gcv_pkg::POS_TRIM_OFS, r);
    `CHK(r, 32'h200, "trim reset value")
    rd(gcv_pkg::SECOND_CONTROL_OFS, r);
    `CHK(r, 32'h100, "second control reset value")
    `CHK({hresp, tn}, 11'h200, "response or negative trim")
  endtask
  task automatic t_trim();
    wr(gcv_pkg::POS_TRIM_OFS, 32'hffff_fd55);
    rd(gcv_pkg::POS_TRIM_OFS, r);
    `CHK({r, tp}, {32'h155, 10'h155}, "trim not masked")
    wr(gcv_pkg::POS_TRIM_OFS, 32'h300);
    wr(gcv_pkg::NEG_TRIM_OFS, 32'h300);
    @(posedge clk);
    `CHK({tp, tn}, 20'hc0300, "common mode trims")
    rd(8'h20, r);
    `CHK(r, 32'h0, "unmapped read")
    wr(gcv_pkg::POS_TRIM_OFS, 32'h200);
    wr(gcv_pkg::NEG_TRIM_OFS, 32'h200);
  endtask
  task automatic t_single();
    logic [15:0] res;
    wr(gcv_pkg::MAIN_CONTROL_OFS, 32'h1);
    pin_func <= 4'hf;
    wr(gcv_pkg::CHANNEL_SELECT_OFS, 32'h2);
    wr(gcv_pkg::MAIN_CONTROL_OFS, 32'h9);
    @(posedge clk);
    `CHK({en, se, chan}, 4'he, "enable, mode or channel")
    convert(32'h9, res);
    `CHK(res, 16'((300 + OP) << 6), "single result")
  endtask
  task automatic t_average();
    logic [15:0] res;
    int n0;
    wr(gcv_pkg::SECOND_CONTROL_OFS, 32'h1322);
    @(posedge clk);
    `CHK({load, smpl, attn}, 7'h4e, "second control fields")
    delay <= 4'h3;
    n0 = reqs;
    convert(32'h1, res);
    `CHK(reqs - n0, 4, "sample count")
    `CHK(res, 16'((4 * (300 + OP) << 6) >> 2), "averaged result")
    delay <= 4'h0;
  endtask
  task automatic t_chop();
    logic [15:0] res;
    int n0;
    wr(gcv_pkg::SECOND_CONTROL_OFS, 32'h100);
    n0 = reqs;
    convert(32'h41, res);
    `CHK(reqs - n0, 2, "chop sample count")
    `CHK(hist[1:0], 2'b01, "sign not alternated")
    `CHK(res, 16'(((600 + OP - ON) << 6) >> 1), "chop result")
  endtask
  // Continuous relaunches until the mode bit drops, then start clears once
  task automatic t_cont();
    int n0, n1, n;
    wr(gcv_pkg::SECOND_CONTROL_OFS, 32'h100);
    n0 = reqs;
    n = 0;
    wr(gcv_pkg::MAIN_CONTROL_OFS, 32'h7);
    while (reqs - n0 < 3 && n < 400) begin
      @(posedge clk);
      n++;
    end
    `CHK(reqs - n0 >= 3, 1'b1, "no relaunch in continuous mode")
    rd(gcv_pkg::MAIN_CONTROL_OFS, r);
    `CHK(r[1], 1'b1, "start cleared while continuous")
    wr(gcv_pkg::MAIN_CONTROL_OFS, 32'h3);
    repeat (30) @(posedge clk);
    n1 = reqs;
    rd(gcv_pkg::MAIN_CONTROL_OFS, r);
    `CHK(r[1], 1'b0, "start kept after continuous ended")
    repeat (30) @(posedge clk);
    `CHK(reqs, n1, "conversion after continuous ended")
    wr(gcv_pkg::INTERRUPT_CLEAR_OFS, 32'h0);
    @(posedge clk);
    `CHK(irq, 1'b0, "interrupt not cleared")
  endtask
  // Base is the mid-scale or common-mode trim the routine centres on
  task automatic t_calib(input logic single, input int base);
    logic [15:0] res;
    logic [31:0] c;
    int op, on, k;
    k = single ? 2 : 1;
    c = {26'h0, 1'b0, 1'b1, single, 3'h1};
    wr(gcv_pkg::SECOND_CONTROL_OFS, 32'h203);
    wr(gcv_pkg::POS_TRIM_OFS, 32'(base));
    wr(gcv_pkg::NEG_TRIM_OFS, 32'(base));
    convert(c, res);
    op = int'(res >> 6) - base;
    `CHK(op, OP, "positive offset")
    convert(c | 32'h20, res);
    on = int'(res >> 6) - base;
    `CHK(on, -ON, "negative offset")
    wr(gcv_pkg::POS_TRIM_OFS, 32'(base - k * op));
    wr(gcv_pkg::NEG_TRIM_OFS, 32'(base - k * on));
    convert(c, res);
    `CHK(res, 16'(base << 6), "positive side after trim")
    convert(c | 32'h20, res);
    `CHK(res, 16'(base << 6), "negative side after trim")
  endtask
  // ----------------------------------------
  // Run control
  // ----------------------------------------
  task automatic end_of_test();
    if (bad_count == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      $display("mismatch at %0t: run timed out", $time);
      end_of_test();
    end
  end
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_trim();
    t_single();
    t_average();
    t_chop();
    t_cont();
    t_calib(1'b1, 512);
    t_calib(1'b0, 512);
    t_calib(1'b0, 768);
    end_of_test();
  end
endmodule // gcv_ctrl_test
